// ---- tape_data_pkg.sv ----
`default_nettype none

package tape_data_pkg;

    localparam int TRACK_COUNT = 9;
    localparam int FIFO_DEPTH = 8;

    // system clock and pulse timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int READ_STROBE_MIN_NS = 1000;
    localparam logic [5:0] READ_STROBE_CYC =
        6'((READ_STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // phase encoded record framing
    localparam logic [5:0] PREAMBLE_ZEROS = 6'h28;
    localparam logic [5:0] POSTAMBLE_ZEROS = 6'h28;

    // read threshold figures in percent of peak amplifier output
    localparam logic [6:0] THR_NRZI_MID_PCT = 7'h19;
    localparam logic [6:0] THR_NRZI_HIGH_PCT = 7'h2D;
    localparam logic [6:0] THR_NRZI_LOW_PCT = 7'h0C;
    localparam logic [6:0] THR_PE_MID_PCT = 7'h0F;
    localparam logic [6:0] THR_PE_HIGH_PCT = 7'h1E;
    localparam logic [6:0] THR_PE_LOW_PCT = 7'h05;

    typedef enum logic [1:0] {
        THR_MID,
        THR_HIGH,
        THR_LOW
    } thr_sel_t;

    typedef enum logic [2:0] {
        WR_IDLE,
        WR_PRE_ZERO,
        WR_PRE_ONE,
        WR_DATA,
        WR_POST_ONE,
        WR_POST_ZERO
    } wr_state_t;

endpackage : tape_data_pkg

`default_nettype wire

// ---- char_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module char_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys_in, // system clock
    input wire logic sys_rst_in, // synchronous reset, active high
    input wire logic in_valid_in, // write side offers a word
    output logic in_ready_out, // room for a word
    input wire logic [WIDTH-1:0] in_data_in, // word to store
    output logic out_valid_out, // a word is waiting
    input wire logic out_ready_in, // drain side takes the word
    output logic [WIDTH-1:0] out_data_out // oldest word
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } fifo_state_t;

    fifo_state_t q;
    fifo_state_t d;
    logic push;
    logic pop;

    assign in_ready_out = (q.count != FULL_COUNT);
    assign out_valid_out = (q.count != '0);
    assign out_data_out = q.mem[q.rd_ptr];

    always_comb
    begin
        d = q;
        push = in_valid_in && in_ready_out;
        pop = out_ready_in && out_valid_out;
        if (push)
        begin
            d.mem[q.wr_ptr] = in_data_in;
            d.wr_ptr = (q.wr_ptr == LAST_PTR) ? '0 : AW'(q.wr_ptr + 1'b1);
        end
        if (pop)
        begin
            d.rd_ptr = (q.rd_ptr == LAST_PTR) ? '0 : AW'(q.rd_ptr + 1'b1);
        end
        if (push && !pop)
        begin
            d.count = CW'(q.count + 1'b1);
        end
        else if (pop && !push)
        begin
            d.count = CW'(q.count - 1'b1);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

endmodule : char_fifo

`default_nettype wire

// ---- tape_unit_data_interface.sv ----
`timescale 1ns/1ps
`default_nettype none

module tape_unit_data_interface
    import tape_data_pkg::*;
#(
    parameter int TRACKS = TRACK_COUNT,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk_sys_in, // system clock, 40 MHz
    input wire logic sys_rst_in, // synchronous reset, active high
    input wire logic data_ready_n_in, // write character strobe pin
    input wire logic [TRACKS-1:0] write_data_n_in, // write data pins
    input wire logic longitudinal_check_pulse_n_in, // record end strobe pin
    input wire logic threshold_select_a_n_in, // threshold select pin a
    input wire logic threshold_select_b_n_in, // threshold select pin b
    input wire logic forward_motion_cmd_n_in, // forward motion pin
    input wire logic reverse_motion_cmd_n_in, // reverse motion pin
    input wire logic write_mode_in, // unit is in write mode
    input wire logic pe_mode_in, // phase encoded density chosen
    input wire logic seven_track_cfg_in, // unit built seven track
    input wire logic single_stack_cfg_in, // unit has one head stack
    input wire logic low_speed_cfg_in, // unit is the slower of a pair
    input wire logic [TRACKS-1:0] head_char_in, // deskewed NRZI read character
    input wire logic head_char_valid_in, // read character ready, one cycle
    input wire logic [TRACKS-1:0] peak_det_in, // PE peak detector levels
    input wire logic [TRACKS-1:0] envelope_det_in, // PE envelope detector levels
    output logic [TRACKS-1:0] wr_char_out, // character to write head
    output logic wr_char_valid_out, // character offered to write head
    input wire logic wr_char_ready_in, // write head takes character
    output logic wr_lrc_out, // write the check character, pulse
    output logic fifo_ready_out, // write buffer has room
    output logic overrun_out, // strobe lost on full buffer
    output logic phase_error_out, // PE half cells without transition
    output logic pe_active_out, // phase encoding in effect
    output logic [1:0] thr_sel_out, // selected threshold
    output logic [6:0] thr_pct_out, // selected threshold in percent
    output logic [TRACKS-1:0] read_data_n_out, // read data pins
    output logic read_data_oe_out, // read data pins driven
    output logic read_strobe_n_out, // NRZI read strobe pin
    output logic seven_track_n_out, // seven track status pin
    output logic single_stack_n_out, // single stack status pin
    output logic nrzi_n_out, // NRZI unit status pin
    output logic low_speed_n_out // low speed status pin
);

    // strobe, data and command pin samples are inverted ahead of the first flop so that
    // those flags are active high and reset to zero; the active low output registers reset to one
    typedef struct packed {
        logic dr_s1;
        logic dr_s2;
        logic dr_s3;
        logic lrc_s1;
        logic lrc_s2;
        logic lrc_s3;
        logic [TRACKS-1:0] wd_s1;
        logic [TRACKS-1:0] wd_s2;
        logic [3:0] cmd_s1;
        logic [3:0] cmd_s2;
        logic [TRACKS-1:0] peak_s1;
        logic [TRACKS-1:0] peak_s2;
        logic [TRACKS-1:0] env_s1;
        logic [TRACKS-1:0] env_s2;
        logic [TRACKS-1:0] half;
        logic half_have;
        logic lrc_pend;
        logic overrun;
        logic phase_err;
        logic fifo_ready;
        wr_state_t st;
        logic [5:0] amble_cnt;
        logic [TRACKS-1:0] wr_char;
        logic wr_valid;
        logic wr_lrc;
        thr_sel_t thr;
        logic [6:0] thr_pct;
        logic pe_act;
        logic [TRACKS-1:0] rd_n;
        logic rd_oe;
        logic strobe_n;
        logic [5:0] strobe_cnt;
        logic seven_n;
        logic single_n;
        logic nrzi_n;
        logic slow_n;
    } state_t;

    localparam state_t RESET_STATE = '{
        st: WR_IDLE,
        thr: THR_MID,
        rd_n: '1,
        strobe_n: 1'b1,
        seven_n: 1'b1,
        single_n: 1'b1,
        nrzi_n: 1'b1,
        slow_n: 1'b1,
        default: '0
    };

    state_t q;
    state_t d;

    logic push_valid;
    logic [TRACKS-1:0] push_data;
    logic push_ready;
    logic pop_ready;
    logic pop_valid;
    logic [TRACKS-1:0] pop_data;
    logic dr_lead;
    logic lrc_lead;
    logic pe_eff;
    logic motion;
    logic out_free;
    logic thr_a;
    logic thr_b;

    char_fifo #(
        .WIDTH(TRACKS),
        .DEPTH(DEPTH)
    ) u_write_fifo (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .in_valid_in(push_valid),
        .in_ready_out(push_ready),
        .in_data_in(push_data),
        .out_valid_out(pop_valid),
        .out_ready_in(pop_ready),
        .out_data_out(pop_data)
    );

    always_comb
    begin
        d = q;
        push_valid = 1'b0;
        push_data = '0;
        pop_ready = 1'b0;

        // two-flop synchronisers, strobe, data and command pins inverted, detector levels not
        d.dr_s1 = ~data_ready_n_in;
        d.dr_s2 = q.dr_s1;
        d.dr_s3 = q.dr_s2;
        d.lrc_s1 = ~longitudinal_check_pulse_n_in;
        d.lrc_s2 = q.lrc_s1;
        d.lrc_s3 = q.lrc_s2;
        d.wd_s1 = ~write_data_n_in;
        d.wd_s2 = q.wd_s1;
        d.cmd_s1 = ~{threshold_select_a_n_in, threshold_select_b_n_in,
                     forward_motion_cmd_n_in, reverse_motion_cmd_n_in};
        d.cmd_s2 = q.cmd_s1;
        d.peak_s1 = peak_det_in;
        d.peak_s2 = q.peak_s1;
        d.env_s1 = envelope_det_in;
        d.env_s2 = q.env_s1;

        dr_lead = q.dr_s2 && !q.dr_s3;
        lrc_lead = q.lrc_s2 && !q.lrc_s3;
        pe_eff = pe_mode_in && !seven_track_cfg_in;
        thr_a = q.cmd_s2[3];
        thr_b = q.cmd_s2[2];
        motion = q.cmd_s2[1] || q.cmd_s2[0];
        d.fifo_ready = push_ready;
        d.pe_act = pe_eff;

        // write capture: data lines and strobe share synchroniser depth,
        // so the sampled character lines up with the detected edge
        if (!write_mode_in)
        begin
            d.half_have = 1'b0;
            d.overrun = 1'b0;
            d.phase_err = 1'b0;
        end
        else if (dr_lead)
        begin
            if (pe_eff && !q.half_have)
            begin
                d.half = q.wd_s2;
                d.half_have = 1'b1;
            end
            else if (pe_eff)
            begin
                // asserted first half then cleared second half is low to high
                push_valid = 1'b1;
                push_data = q.half & ~q.wd_s2;
                d.half_have = 1'b0;
                if ((q.half ^ q.wd_s2) != '1)
                begin
                    d.phase_err = 1'b1;
                end
            end
            else
            begin
                push_valid = 1'b1;
                push_data = q.wd_s2;
            end
            // pins cannot be stalled: a strobe on a full buffer is lost
            if (push_valid && !push_ready)
            begin
                d.overrun = 1'b1;
            end
        end

        // write head feed: one registered stage with valid and ready
        out_free = !q.wr_valid || wr_char_ready_in;
        d.wr_lrc = 1'b0;
        if (out_free)
        begin
            d.wr_valid = 1'b0;
        end
        unique case (q.st)
            WR_IDLE:
            begin
                if (pop_valid)
                begin
                    d.st = pe_eff ? WR_PRE_ZERO : WR_DATA;
                    d.amble_cnt = '0;
                end
                else if (q.lrc_pend)
                begin
                    d.st = WR_DATA;
                end
            end
            WR_PRE_ZERO:
            begin
                if (out_free)
                begin
                    d.wr_char = '0;
                    d.wr_valid = 1'b1;
                    d.amble_cnt = 6'(q.amble_cnt + 1'b1);
                    if (q.amble_cnt == 6'(PREAMBLE_ZEROS - 1'b1))
                    begin
                        d.st = WR_PRE_ONE;
                    end
                end
            end
            WR_PRE_ONE:
            begin
                if (out_free)
                begin
                    d.wr_char = '1;
                    d.wr_valid = 1'b1;
                    d.st = WR_DATA;
                end
            end
            WR_DATA:
            begin
                if (out_free && pop_valid)
                begin
                    pop_ready = 1'b1;
                    d.wr_char = pop_data;
                    d.wr_valid = 1'b1;
                end
                else if (out_free && q.lrc_pend)
                begin
                    // check strobe closes the record once the buffer is dry
                    d.lrc_pend = 1'b0;
                    d.amble_cnt = '0;
                    if (pe_eff)
                    begin
                        d.st = WR_POST_ONE;
                    end
                    else
                    begin
                        d.wr_lrc = 1'b1;
                        d.st = WR_IDLE;
                    end
                end
            end
            WR_POST_ONE:
            begin
                if (out_free)
                begin
                    d.wr_char = '1;
                    d.wr_valid = 1'b1;
                    d.st = WR_POST_ZERO;
                end
            end
            WR_POST_ZERO:
            begin
                if (out_free)
                begin
                    d.wr_char = '0;
                    d.wr_valid = 1'b1;
                    d.amble_cnt = 6'(q.amble_cnt + 1'b1);
                    if (q.amble_cnt == 6'(POSTAMBLE_ZEROS - 1'b1))
                    begin
                        d.st = WR_IDLE;
                    end
                end
            end
        endcase
        // a new strobe in the cycle the old one is consumed stays pending
        if (write_mode_in && lrc_lead)
        begin
            d.lrc_pend = 1'b1;
        end

        // read threshold; both selects asserted falls back to mid
        if (write_mode_in)
        begin
            d.thr = THR_HIGH;
        end
        else if (thr_a && !thr_b)
        begin
            d.thr = THR_HIGH;
        end
        else if (thr_b && !thr_a)
        begin
            d.thr = THR_LOW;
        end
        else
        begin
            d.thr = THR_MID;
        end
        unique case (d.thr)
            THR_HIGH: d.thr_pct = pe_eff ? THR_PE_HIGH_PCT : THR_NRZI_HIGH_PCT;
            THR_LOW: d.thr_pct = pe_eff ? THR_PE_LOW_PCT : THR_NRZI_LOW_PCT;
            default: d.thr_pct = pe_eff ? THR_PE_MID_PCT : THR_NRZI_MID_PCT;
        endcase

        // read path
        d.rd_oe = motion;
        if (!motion)
        begin
            d.rd_n = '1;
            d.strobe_n = 1'b1;
            d.strobe_cnt = '0;
        end
        else if (pe_eff)
        begin
            d.rd_n = ~(q.peak_s2 & q.env_s2);
            d.strobe_n = 1'b1;
            d.strobe_cnt = '0;
        end
        else if (q.strobe_cnt != '0)
        begin
            // characters arriving inside a strobe are dropped; the head
            // rate leaves several strobe widths between characters
            d.strobe_cnt = 6'(q.strobe_cnt - 1'b1);
            if (q.strobe_cnt == 6'h01)
            begin
                d.strobe_n = 1'b1;
            end
        end
        else if (head_char_valid_in)
        begin
            d.rd_n = ~head_char_in;
            d.strobe_n = 1'b0;
            d.strobe_cnt = READ_STROBE_CYC;
        end

        // static status lines
        d.seven_n = ~seven_track_cfg_in;
        d.single_n = ~single_stack_cfg_in;
        d.nrzi_n = pe_eff;
        d.slow_n = ~low_speed_cfg_in;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            q <= RESET_STATE;
        end
        else
        begin
            q <= d;
        end
    end

    assign wr_char_out = q.wr_char;
    assign wr_char_valid_out = q.wr_valid;
    assign wr_lrc_out = q.wr_lrc;
    assign fifo_ready_out = q.fifo_ready;
    assign overrun_out = q.overrun;
    assign phase_error_out = q.phase_err;
    assign pe_active_out = q.pe_act;
    assign thr_sel_out = q.thr;
    assign thr_pct_out = q.thr_pct;
    assign read_data_n_out = q.rd_n;
    assign read_data_oe_out = q.rd_oe;
    assign read_strobe_n_out = q.strobe_n;
    assign seven_track_n_out = q.seven_n;
    assign single_stack_n_out = q.single_n;
    assign nrzi_n_out = q.nrzi_n;
    assign low_speed_n_out = q.slow_n;

endmodule : tape_unit_data_interface

`default_nettype wire

// ---- tape_unit_data_interface_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module tape_unit_data_interface_assertions
    import tape_data_pkg::*;
#(
    parameter int TRACKS = TRACK_COUNT
) (
    input wire logic clk_sys_in, // system clock
    input wire logic sys_rst_in, // synchronous reset
    input wire logic write_mode_in, // write mode
    input wire logic pe_mode_in, // phase encoded chosen
    input wire logic seven_track_cfg_in, // seven track unit
    input wire logic [TRACKS-1:0] head_char_in, // read character
    input wire logic head_char_valid_in, // read character pulse
    input wire logic wr_char_ready_in, // head takes character
    input wire logic [TRACKS-1:0] wr_char_out, // character to head
    input wire logic wr_char_valid_out, // character offered
    input wire logic overrun_out, // sticky overrun
    input wire logic pe_active_out, // phase encoding in effect
    input wire logic [1:0] thr_sel_out, // selected threshold
    input wire logic [TRACKS-1:0] read_data_n_out, // read data pins
    input wire logic read_data_oe_out, // read data driven
    input wire logic read_strobe_n_out, // read strobe pin
    input wire logic seven_track_n_out // seven track pin
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    // counts edges with the strobe low, cleared whenever it is high
    logic [6:0] low_q;
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in || read_strobe_n_out)
            low_q <= 7'h00;
        else
            low_q <= low_q + 7'h01;
    end

    seven_track_pin_a: assert property ($past(!sys_rst_in) |-> seven_track_n_out == !$past(seven_track_cfg_in)) else $error("seven track pin wrong");
    pe_only_nine_a: assert property ($past(!sys_rst_in) |-> pe_active_out == $past(pe_mode_in && !seven_track_cfg_in)) else $error("pe active wrong");
    write_forces_high_a: assert property ($past(!sys_rst_in) && $past(write_mode_in) |-> thr_sel_out == THR_HIGH) else $error("threshold not high in write");
    strobe_width_a: assert property ($rose(read_strobe_n_out) |-> low_q == 7'(READ_STROBE_CYC)) else $error("read strobe width wrong");
    undriven_idle_a: assert property (!read_data_oe_out |-> read_data_n_out == '1) else $error("read data shown while undriven");
    pe_no_strobe_a: assert property (pe_active_out && $past(pe_active_out) |-> read_strobe_n_out) else $error("strobe in pe");
    nrzi_read_a: assert property (head_char_valid_in && !(pe_mode_in && !seven_track_cfg_in) && read_data_oe_out && read_strobe_n_out |=> !read_strobe_n_out && read_data_n_out == ~$past(head_char_in)) else $error("nrzi read char wrong");
    char_hold_a: assert property (wr_char_valid_out && !wr_char_ready_in |=> wr_char_valid_out && $stable(wr_char_out)) else $error("write char not held");
    overrun_sticky_a: assert property (overrun_out && write_mode_in |=> overrun_out) else $error("overrun lost");

    cover property ($fell(read_strobe_n_out));
    cover property ($rose(overrun_out));
    cover property (wr_char_valid_out && wr_char_ready_in && wr_char_out == '1);
endmodule : tape_unit_data_interface_assertions

bind tape_unit_data_interface tape_unit_data_interface_assertions #(.TRACKS(TRACKS)) chk (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .write_mode_in(write_mode_in),
    .pe_mode_in(pe_mode_in), .seven_track_cfg_in(seven_track_cfg_in),
    .head_char_in(head_char_in), .head_char_valid_in(head_char_valid_in),
    .wr_char_ready_in(wr_char_ready_in), .wr_char_out(wr_char_out),
    .wr_char_valid_out(wr_char_valid_out), .overrun_out(overrun_out),
    .pe_active_out(pe_active_out), .thr_sel_out(thr_sel_out),
    .read_data_n_out(read_data_n_out), .read_data_oe_out(read_data_oe_out),
    .read_strobe_n_out(read_strobe_n_out), .seven_track_n_out(seven_track_n_out));

`default_nettype wire

// ---- formatter_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module formatter_model (
    output logic data_ready_n_out, // data ready pin
    output logic [8:0] write_data_n_out, // write data pins
    output logic lrc_n_out // check strobe pin
);
    initial
    begin
        data_ready_n_out = 1'b1;
        write_data_n_out = 9'h1FF;
        lrc_n_out = 1'b1;
    end

    // odd offsets keep the pins out of phase with the system clock
    task strobe(input logic [8:0] pins);
        #37 write_data_n_out = pins;
        #100 data_ready_n_out = 1'b0;
        #1000 data_ready_n_out = 1'b1;
        #50 write_data_n_out = ~pins;
        #100;
    endtask : strobe

    task check_pulse;
        #4000 lrc_n_out = 1'b0;
        #1000 lrc_n_out = 1'b1;
        #100;
    endtask : check_pulse
endmodule : formatter_model

`default_nettype wire

// ---- tape_unit_data_interface_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tape_unit_data_interface_tb;
    import tape_data_pkg::*;
    logic clk_sys_in = 0, sys_rst_in = 1, wr_mode = 0, pe_mode = 0, seven = 0, single = 0;
    logic low_spd = 0, thr_a_n = 1, thr_b_n = 1, fwd_n = 1, rev_n = 1, hc_valid = 0, wr_ready = 0;
    logic [8:0] head_char = 9'h000, peak = 9'h000, env = 9'h000;
    logic dr_n, lrc_n, wr_valid, wr_lrc, fifo_ready, overrun, phase_err, pe_active, oe, strobe_n;
    logic seven_n, single_n, nrzi_n, low_n;
    logic [8:0] wd_n, wr_char, rd_n;
    logic [1:0] thr_sel;
    logic [6:0] thr_pct;
    int n_fail = 0, tests_run = 0;

    initial
    begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    formatter_model fmt (.data_ready_n_out(dr_n), .write_data_n_out(wd_n), .lrc_n_out(lrc_n));

    tape_unit_data_interface uut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .data_ready_n_in(dr_n), .write_data_n_in(wd_n), .longitudinal_check_pulse_n_in(lrc_n),
        .threshold_select_a_n_in(thr_a_n), .threshold_select_b_n_in(thr_b_n),
        .forward_motion_cmd_n_in(fwd_n), .reverse_motion_cmd_n_in(rev_n),
        .write_mode_in(wr_mode), .pe_mode_in(pe_mode), .seven_track_cfg_in(seven),
        .single_stack_cfg_in(single), .low_speed_cfg_in(low_spd), .head_char_in(head_char),
        .head_char_valid_in(hc_valid), .peak_det_in(peak), .envelope_det_in(env),
        .wr_char_out(wr_char), .wr_char_valid_out(wr_valid), .wr_char_ready_in(wr_ready),
        .wr_lrc_out(wr_lrc), .fifo_ready_out(fifo_ready), .overrun_out(overrun),
        .phase_error_out(phase_err), .pe_active_out(pe_active), .thr_sel_out(thr_sel),
        .thr_pct_out(thr_pct), .read_data_n_out(rd_n), .read_data_oe_out(oe),
        .read_strobe_n_out(strobe_n), .seven_track_n_out(seven_n),
        .single_stack_n_out(single_n), .nrzi_n_out(nrzi_n), .low_speed_n_out(low_n));

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task tick;
        @(posedge clk_sys_in);
        #2;
    endtask : tick

    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : chk

    task automatic wait_lv(ref logic s, input logic v, input int lim);
        for (int i = 0; i < lim && s !== v; i++)
            tick();
        if (s !== v)
        begin
            $display("wrong value wait expected %b seen %b", v, s);
            n_fail++;
            report_and_stop();
        end
    endtask : wait_lv

    // takes one character from the write head side
    task take(output logic [8:0] c);
        wait_lv(wr_valid, 1'b1, 400);
        c = wr_char;
        wr_ready = 1'b1;
        tick();
        wr_ready = 1'b0;
        // one idle edge so a following call never raises ready in the same step
        tick();
    endtask : take

    task status_test;
        seven = 1; single = 1; low_spd = 1; pe_mode = 1;
        repeat (2) tick();
        chk("status low", 16'h0000, 16'({seven_n, single_n, nrzi_n, low_n, pe_active}));
        seven = 0; single = 0; low_spd = 0;
        repeat (2) tick();
        chk("status high", 16'h001F, 16'({seven_n, single_n, nrzi_n, low_n, pe_active}));
    endtask : status_test

    task thr_test;
        logic [1:0] es;
        logic [6:0] ep;
        for (int m = 0; m < 2; m++)
            for (int k = 0; k < 4; k++)
            begin
                pe_mode = m[0]; thr_a_n = k[0]; thr_b_n = k[1];
                repeat (5) tick();
                es = (k == 2) ? THR_HIGH : (k == 1) ? THR_LOW : THR_MID;
                ep = (es == THR_HIGH) ? (m ? THR_PE_HIGH_PCT : THR_NRZI_HIGH_PCT) :
                    (es == THR_LOW) ? (m ? THR_PE_LOW_PCT : THR_NRZI_LOW_PCT) :
                    (m ? THR_PE_MID_PCT : THR_NRZI_MID_PCT);
                chk("thr sel", 16'(es), 16'(thr_sel));
                chk("thr pct", 16'(ep), 16'(thr_pct));
            end
        thr_a_n = 1; thr_b_n = 0; wr_mode = 1;
        repeat (3) tick();
        chk("write thr", 16'(THR_PE_HIGH_PCT), 16'(thr_pct));
    endtask : thr_test

    task pe_write_test;
        logic [8:0] c, e;
        fmt.strobe(~9'h0A6);
        chk("phase error first half", 16'h0000, 16'(phase_err));
        // track 8 stays high in both halves: no transition, bit reads zero
        fmt.strobe(9'h1A6);
        chk("phase error", 16'h0001, 16'(phase_err));
        fmt.check_pulse();
        for (int i = 0; i < 83; i++)
        begin
            take(c);
            e = (i == 40 || i == 42) ? 9'h1FF : (i == 41) ? 9'h0A6 : 9'h000;
            chk("pe frame char", 16'(e), 16'(c));
        end
        wr_mode = 0;
        tick();
    endtask : pe_write_test

    task nrzi_write_test;
        logic [8:0] c;
        int n;
        pe_mode = 0; wr_mode = 1;
        for (int i = 1; i <= 11; i++)
            fmt.strobe(~9'(i));
        chk("overrun", 16'h0001, 16'(overrun));
        chk("fifo full", 16'h0000, 16'(fifo_ready));
        take(c);
        chk("first char", 16'h0001, 16'(c));
        n = 1;
        while (wr_valid === 1'b1 && n < 20)
        begin
            take(c);
            chk("drain char", 16'(n + 1), 16'(c));
            n++;
        end
        chk("drained", 16'(FIFO_DEPTH + 1), 16'(n));
        fmt.strobe(~9'h155);
        take(c);
        chk("nrzi char", 16'h0155, 16'(c));
        // the check pulse lasts one cycle, so watch for it while the strobe runs
        fork
            fmt.check_pulse();
            begin
                wait_lv(wr_lrc, 1'b1, 300);
                chk("lrc pulse", 16'h0001, 16'(wr_lrc));
            end
        join
        wr_mode = 0;
        repeat (2) tick();
        chk("overrun clear", 16'h0000, 16'(overrun));
        chk("phase clear", 16'h0000, 16'(phase_err));
    endtask : nrzi_write_test

    task read_test;
        int n;
        fwd_n = 0;
        repeat (5) tick();
        head_char = 9'h133; hc_valid = 1;
        tick();
        hc_valid = 0;
        chk("nrzi read", 16'h00CC, 16'(rd_n));
        n = 0;
        while (strobe_n === 1'b0 && n < 100)
        begin
            n++;
            tick();
        end
        chk("strobe width", 16'(READ_STROBE_CYC), 16'(n));
        fwd_n = 1; rev_n = 0;
        repeat (5) tick();
        chk("rev oe", 16'h0001, 16'(oe));
        pe_mode = 1; peak = 9'h0F0; env = 9'h03C;
        repeat (5) tick();
        chk("pe read", 16'h01CF, 16'(rd_n));
        chk("pe strobe", 16'h0001, 16'(strobe_n));
        rev_n = 1;
        repeat (5) tick();
        chk("idle read", 16'h01FF, {6'h00, oe, rd_n});
    endtask : read_test

    initial
    begin
        repeat (10) tick();
        sys_rst_in = 0;
        repeat (4) tick();
        status_test();
        thr_test();
        pe_write_test();
        nrzi_write_test();
        read_test();
        report_and_stop();
    end
endmodule : tape_unit_data_interface_tb

`default_nettype wire
